// ===== core/uicf_pkg.sv
package uicf_pkg;
  typedef logic [7:0] uicf_lvl_t;
  typedef logic [5:0] uicf_src_t;

  // Register byte offsets
  localparam logic [7:0] OFF_IMASK = 8'h00;
  localparam logic [7:0] OFF_ISRC = 8'h04;
  localparam logic [7:0] OFF_FSET = 8'h08;
  localparam logic [7:0] OFF_TTAB = 8'h0c;
  localparam logic [7:0] OFF_EFR = 8'h10;
  localparam logic [7:0] OFF_TRG = 8'h14;

  // Values after reset
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] TTAB_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam uicf_lvl_t TRG_RST = 8'h01;

  // Field positions
  localparam int FS_EN = 0;
  localparam int FS_RXRST = 1;
  localparam int FS_TXRST = 2;
  localparam int FS_DMA = 3;
  localparam int FS_TXSEL = 4;
  localparam int FS_RXSEL = 6;
  localparam int IM_RX = 0;
  localparam int IM_TX = 1;
  localparam int IM_LSR = 2;
  localparam int IM_MSR = 3;
  localparam int IM_XOFF = 5;
  localparam int IM_RTS = 6;
  localparam int IM_CTS = 7;
  localparam int EF_GATE = 4;
  localparam int EF_ARTS = 6;
  localparam int EF_ACTS = 7;
  localparam int TT_RS485 = 3;
  localparam int TT_TAB = 4;
  localparam int TT_TRGTX = 7;

  // Interrupt source codes, highest priority first
  localparam uicf_src_t SRC_LSR = 6'h06;
  localparam uicf_src_t SRC_TOUT = 6'h0c;
  localparam uicf_src_t SRC_RXD = 6'h04;
  localparam uicf_src_t SRC_TXR = 6'h02;
  localparam uicf_src_t SRC_MSR = 6'h00;
  localparam uicf_src_t SRC_XOFF = 6'h10;
  localparam uicf_src_t SRC_FLOW = 6'h20;
  localparam uicf_src_t SRC_NONE = 6'h01;

  localparam uicf_lvl_t FIFO_DEPTH = 8'h80;
  localparam logic [6:0] TOUT_CHARS = 7'h04;
  localparam logic [6:0] TOUT_BITS = 7'h0c;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Trigger tables A, B, C indexed by the two select bits; TX_TAB_A is one fixed level
  localparam uicf_lvl_t RX_TAB_A [4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
  localparam uicf_lvl_t RX_TAB_B [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
  localparam uicf_lvl_t TX_TAB_B [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
  localparam uicf_lvl_t RX_TAB_C [4] = '{8'h08, 8'h10, 8'h38, 8'h3c};
  localparam uicf_lvl_t TX_TAB_C [4] = '{8'h08, 8'h10, 8'h20, 8'h38};
  localparam uicf_lvl_t TX_TAB_A = 8'h01;

  typedef enum logic [1:0] {TAB_A, TAB_B, TAB_C, TAB_D} uicf_tab_e;
endpackage

// ===== core/uicf_trig_if.sv
`timescale 1ns/1ps
interface uicf_trig_if;
  import uicf_pkg::*;
  uicf_tab_e tab;
  logic [1:0] rx_sel;
  logic [1:0] tx_sel;
  uicf_lvl_t trg_rx;
  uicf_lvl_t trg_tx;
  uicf_lvl_t rx_trig;
  uicf_lvl_t tx_trig;
  modport ctrl (output tab, rx_sel, tx_sel, trg_rx, trg_tx,
                input rx_trig, tx_trig);
  modport dec (input tab, rx_sel, tx_sel, trg_rx, trg_tx,
               output rx_trig, tx_trig);
endinterface // uicf_trig_if

// ===== core/uicf_trig.sv
`timescale 1ns/1ps
module uicf_trig (
  uicf_trig_if.dec t
);
  import uicf_pkg::*;

  // One table choice shared by both directions
  always_comb begin
    unique case (t.tab)
      TAB_A: begin
        t.rx_trig = RX_TAB_A[t.rx_sel];
        t.tx_trig = TX_TAB_A;
      end
      TAB_B: begin
        t.rx_trig = RX_TAB_B[t.rx_sel];
        t.tx_trig = TX_TAB_B[t.tx_sel];
      end
      TAB_C: begin
        t.rx_trig = RX_TAB_C[t.rx_sel];
        t.tx_trig = TX_TAB_C[t.tx_sel];
      end
      TAB_D: begin
        t.rx_trig = t.trg_rx;
        t.tx_trig = t.trg_tx;
      end
    endcase
  end
endmodule // uicf_trig

// ===== core/uicf_tout.sv
`timescale 1ns/1ps
module uicf_tout (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  output logic expire
);
  import uicf_pkg::*;
  logic [6:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [6:0] span;

  assign span = 7'(TOUT_CHARS * {3'h0, char_bits}) + TOUT_BITS;

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    expire = 1'b0;
    if (restart || !run) begin
      cnt_d = 7'h00;
      done_d = 1'b0;
    end else if (bit_tick && !done_q) begin
      if (cnt_q == span - 7'h01) begin
        expire = 1'b1;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule // uicf_tout

// ===== core/uicf_ctrl.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module uicf_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uicf_pkg::uicf_lvl_t rx_level,
  input wire uicf_pkg::uicf_lvl_t tx_level,
  input wire logic rhr_full,
  input wire logic thr_empty,
  input wire logic tx_empty,
  input wire logic [3:0] line_err,
  input wire logic [3:0] modem_delta,
  input wire logic cts_in,
  input wire logic rts_out,
  input wire logic char_rx,
  input wire logic xoff_rx,
  input wire logic xon_rx,
  input wire logic special_rx,
  input wire logic line_condition_read,
  input wire logic modem_condition_read,
  input wire logic receive_holding_read,
  input wire logic transmit_holding_write,
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  output logic fifo_en,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic dma_mode,
  output logic auto_cts_en,
  output logic auto_rts_en,
  output logic rs485_en,
  output logic irq_pending,
  output logic rx_dma_request_pin_n,
  output logic tx_dma_request_pin_n
);
  import uicf_pkg::*;

  uicf_trig_if trig ();
  logic tout_exp;

  // Bus state
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d, wd_q, wd_d;
  logic ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  // Core state
  logic [7:0] im_q, im_d, tt_q, tt_d, ef_q, ef_d;
  uicf_lvl_t trx_q, trx_d, ttx_q, ttx_d;
  logic fe_q, fe_d, dma_q, dma_d, rxr_q, rxr_d, txr_q, txr_d;
  logic [1:0] rsel_q, rsel_d, tsel_q, tsel_d;
  logic lsr_f_q, lsr_f_d, to_f_q, to_f_d, tr_f_q, tr_f_d;
  logic ms_f_q, ms_f_d, xo_f_q, xo_f_d, sp_f_q, sp_f_d, fl_f_q, fl_f_d;
  logic the_q, txe_q, cts_q, rts_q, over_q, over_d;
  uicf_lvl_t txl_q;
  logic irq_q, irq_d, rdn_q, rdn_d, tdn_q, tdn_d;

  logic do_wr, rd_hs, isr_rd;
  logic p_lsr, p_to, p_rxd, p_tr, p_ms, p_xo, p_fl;
  logic rx_at_trig, tr_set, lsr_set, ms_set;
  uicf_src_t src;

  function automatic logic [7:0] rd_mux(input logic [7:0] a,
      input logic [7:0] im, input logic [7:0] interrupt_source,
      input logic [7:0] tt, input logic [7:0] ef,
      input logic [15:0] trg, output logic hit);
    hit = 1'b1;
    unique case (a)
      OFF_IMASK: rd_mux = im;
      OFF_ISRC: rd_mux = interrupt_source;
      OFF_FSET: rd_mux = 8'h00;
      OFF_TTAB: rd_mux = tt;
      OFF_EFR: rd_mux = ef;
      OFF_TRG: rd_mux = tt[TT_TRGTX] ? trg[15:8] : trg[7:0];
      default: begin
        rd_mux = 8'h00;
        hit = 1'b0;
      end
    endcase
  endfunction

  assign trig.tab = uicf_tab_e'(tt_q[TT_TAB +: 2]);
  assign trig.rx_sel = rsel_q;
  assign trig.tx_sel = tsel_q;
  assign trig.trg_rx = trx_q;
  assign trig.trg_tx = ttx_q;

  uicf_trig u_trig (
    .t(trig.dec)
  );

  uicf_tout u_tout (
    .clk(clk),
    .rst_n(rst_n),
    .run(fe_q && rx_level != 8'h00),
    .restart(char_rx || receive_holding_read),
    .bit_tick(bit_tick),
    .char_bits(char_bits),
    .expire(tout_exp)
  );

  // Pending sources after masking
  assign rx_at_trig = rx_level >= trig.rx_trig;
  assign p_lsr = lsr_f_q && im_q[IM_LSR];
  assign p_to = to_f_q && im_q[IM_RX];
  assign p_rxd = im_q[IM_RX] && (fe_q ? rx_at_trig : rhr_full);
  assign p_tr = tr_f_q && im_q[IM_TX];
  assign p_ms = ms_f_q && im_q[IM_MSR];
  assign p_xo = (xo_f_q || sp_f_q) && im_q[IM_XOFF];
  assign p_fl = fl_f_q && (im_q[IM_CTS] || im_q[IM_RTS]);

  // Only the top source is visible; lower ones stay queued
  always_comb begin
    if (p_lsr) src = SRC_LSR;
    else if (p_to) src = SRC_TOUT;
    else if (p_rxd) src = SRC_RXD;
    else if (p_tr) src = SRC_TXR;
    else if (p_ms) src = SRC_MSR;
    else if (p_xo) src = SRC_XOFF;
    else if (p_fl) src = SRC_FLOW;
    else src = SRC_NONE;
  end

  // AXI4-Lite slave; one write and one read outstanding
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign do_wr = aw_q && w_q && !bv_q;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  assign isr_rd = rd_hs && s_axi_araddr == OFF_ISRC;

  always_comb begin
    logic hit;
    logic [7:0] b;
    hit = 1'b0;
    b = 8'h00;
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      b = rd_mux(awa_q, im_q, 8'h00, tt_q, ef_q, 16'h0000, hit);
      br_d = (hit && awa_q != OFF_ISRC) ? AXI_OKAY : AXI_SLVERR;
    end else if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rd_hs) begin
      rv_d = 1'b1;
      b = rd_mux(s_axi_araddr, im_q, {{2{fe_q}}, src}, tt_q, ef_q,
                 {ttx_q, trx_q}, hit);
      rd_d = {24'h000000, b};
      rr_d = hit ? AXI_OKAY : AXI_SLVERR;
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= AXI_OKAY;
      rv_q <= 1'b0;
      rr_q <= AXI_OKAY;
      rd_q <= 32'h00000000;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;

  // Hardware events; each set outranks a clear in the same cycle
  assign lsr_set = char_rx && |line_err;
  assign ms_set = |modem_delta;
  always_comb begin
    tr_set = 1'b0;
    if (rs485_en) tr_set = tx_empty && !txe_q;
    else if (!fe_q) tr_set = thr_empty && !the_q;
    else if (txl_q >= trig.tx_trig && tx_level < trig.tx_trig)
      tr_set = 1'b1;
    else if (tx_level == 8'h00 && txl_q != 8'h00 && !over_q)
      tr_set = 1'b1;
  end

  always_comb begin
    logic wr;
    wr = do_wr && ws_q;
    im_d = im_q;
    tt_d = tt_q;
    ef_d = ef_q;
    trx_d = trx_q;
    ttx_d = ttx_q;
    fe_d = fe_q;
    dma_d = dma_q;
    rsel_d = rsel_q;
    tsel_d = tsel_q;
    rxr_d = 1'b0;
    txr_d = 1'b0;
    over_d = over_q;
    lsr_f_d = lsr_f_q;
    to_f_d = to_f_q;
    tr_f_d = tr_f_q;
    ms_f_d = ms_f_q;
    xo_f_d = xo_f_q;
    sp_f_d = sp_f_q;
    fl_f_d = fl_f_q;
    if (wr && awa_q == OFF_IMASK) begin
      im_d[3:0] = wd_q[3:0];
      if (ef_q[EF_GATE]) im_d[7:4] = wd_q[7:4];
      if (wd_q[IM_TX] && !im_q[IM_TX] &&
          (fe_q ? tx_level == 8'h00 : thr_empty))
        tr_f_d = 1'b1;
    end
    if (wr && awa_q == OFF_FSET) begin
      fe_d = wd_q[FS_EN];
      if (wd_q[FS_EN]) begin
        rxr_d = wd_q[FS_RXRST];
        txr_d = wd_q[FS_TXRST];
        dma_d = wd_q[FS_DMA];
        rsel_d = wd_q[FS_RXSEL +: 2];
        if (ef_q[EF_GATE]) tsel_d = wd_q[FS_TXSEL +: 2];
      end
    end
    if (wr && awa_q == OFF_TTAB) tt_d = wd_q;
    if (wr && awa_q == OFF_EFR) ef_d = wd_q;
    if (wr && awa_q == OFF_TRG) begin
      if (tt_q[TT_TRGTX]) ttx_d = wd_q;
      else trx_d = wd_q;
    end
    // Reload above trigger decides whether empty alone may interrupt
    if (tx_level > trig.tx_trig) over_d = 1'b1;
    else if (tx_level == 8'h00) over_d = 1'b0;
    // Clears first, sets after so that sets win
    if (line_condition_read) lsr_f_d = 1'b0;
    if (receive_holding_read) to_f_d = 1'b0;
    if (transmit_holding_write || (isr_rd && src == SRC_TXR))
      tr_f_d = 1'b0;
    if (modem_condition_read) begin
      ms_f_d = 1'b0;
      fl_f_d = 1'b0;
    end
    if (xon_rx || (isr_rd && src == SRC_XOFF)) xo_f_d = 1'b0;
    if (char_rx || (isr_rd && src == SRC_XOFF)) sp_f_d = 1'b0;
    if (lsr_set) lsr_f_d = 1'b1;
    if (tout_exp && fe_q) to_f_d = 1'b1;
    if (tr_set) tr_f_d = 1'b1;
    if (ms_set) ms_f_d = 1'b1;
    if (xoff_rx) xo_f_d = 1'b1;
    if (special_rx) sp_f_d = 1'b1;
    if ((ef_q[EF_ACTS] && im_q[IM_CTS] && cts_in && !cts_q) ||
        (ef_q[EF_ARTS] && im_q[IM_RTS] && rts_out && !rts_q))
      fl_f_d = 1'b1;
    irq_d = src != SRC_NONE;
    // Request pins are low while service is wanted
    rdn_d = !(dma_q ? (rx_at_trig || to_f_q)
                    : (fe_q ? rx_level != 8'h00 : rhr_full));
    tdn_d = !(dma_q ? tx_level < FIFO_DEPTH
                    : (fe_q ? tx_level == 8'h00 : thr_empty));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      im_q <= IMASK_RST;
      tt_q <= TTAB_RST;
      ef_q <= EFR_RST;
      trx_q <= TRG_RST;
      ttx_q <= TRG_RST;
      fe_q <= 1'b0;
      dma_q <= 1'b0;
      rsel_q <= 2'h0;
      tsel_q <= 2'h0;
      rxr_q <= 1'b0;
      txr_q <= 1'b0;
      over_q <= 1'b0;
      lsr_f_q <= 1'b0;
      to_f_q <= 1'b0;
      tr_f_q <= 1'b0;
      ms_f_q <= 1'b0;
      xo_f_q <= 1'b0;
      sp_f_q <= 1'b0;
      fl_f_q <= 1'b0;
      the_q <= 1'b1;
      txe_q <= 1'b1;
      cts_q <= 1'b0;
      rts_q <= 1'b0;
      txl_q <= 8'h00;
      irq_q <= 1'b0;
      rdn_q <= 1'b1;
      tdn_q <= 1'b1;
    end else begin
      im_q <= im_d;
      tt_q <= tt_d;
      ef_q <= ef_d;
      trx_q <= trx_d;
      ttx_q <= ttx_d;
      fe_q <= fe_d;
      dma_q <= dma_d;
      rsel_q <= rsel_d;
      tsel_q <= tsel_d;
      rxr_q <= rxr_d;
      txr_q <= txr_d;
      over_q <= over_d;
      lsr_f_q <= lsr_f_d;
      to_f_q <= to_f_d;
      tr_f_q <= tr_f_d;
      ms_f_q <= ms_f_d;
      xo_f_q <= xo_f_d;
      sp_f_q <= sp_f_d;
      fl_f_q <= fl_f_d;
      the_q <= thr_empty;
      txe_q <= tx_empty;
      cts_q <= cts_in;
      rts_q <= rts_out;
      txl_q <= tx_level;
      irq_q <= irq_d;
      rdn_q <= rdn_d;
      tdn_q <= tdn_d;
    end
  end

  assign fifo_en = fe_q;
  assign rx_fifo_reset = rxr_q;
  assign tx_fifo_reset = txr_q;
  assign dma_mode = dma_q;
  assign auto_cts_en = ef_q[EF_ACTS];
  assign auto_rts_en = ef_q[EF_ARTS];
  assign rs485_en = tt_q[TT_RS485];
  assign irq_pending = irq_q;
  assign rx_dma_request_pin_n = rdn_q;
  assign tx_dma_request_pin_n = tdn_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_src_idle_code: assert property (
    !(p_lsr || p_to || p_rxd || p_tr || p_ms || p_xo || p_fl)
      |-> src == SRC_NONE) else $error("idle source code wrong");
  a_src_lsr_top: assert property (
    p_lsr |-> src == SRC_LSR) else $error("line status not on top");
  a_isr_fifo_bits: assert property (
    isr_rd |=> s_axi_rdata[7:6] == {2{$past(fe_q)}})
    else $error("source bits 7:6 disagree with FIFO enable");
  a_lsr_read_clr: assert property (
    line_condition_read && !lsr_set |=> !lsr_f_q)
    else $error("line status flag not cleared");
  a_thr_write_clr: assert property (
    transmit_holding_write && !tr_set |=> !tr_f_q)
    else $error("transmit ready not cleared");
  a_modem_read_clr: assert property (
    modem_condition_read && !ms_set |=> !ms_f_q ##0 !fl_f_q)
    else $error("modem flags not cleared");
  a_mask_hi_gate: assert property (
    do_wr && awa_q == OFF_IMASK && !ef_q[EF_GATE]
      |=> im_q[7:4] == $past(im_q[7:4]))
    else $error("upper mask bits changed without gate");
  a_setup_en_gate: assert property (
    do_wr && ws_q && awa_q == OFF_FSET && !wd_q[FS_EN]
      |=> !fe_q && $stable(dma_q) && $stable(rsel_q) && !rxr_q)
    else $error("setup bits taken without enable");
  a_reset_pulse: assert property (
    rxr_q || txr_q |=> !rxr_q && !txr_q)
    else $error("FIFO reset bit did not return to 0");
  a_timeout_flag: assert property (
    tout_exp && fe_q |=> to_f_q) else $error("timeout not flagged");
  a_irq_follows: assert property (
    src != SRC_NONE |=> irq_q) else $error("pending not reported");

  c_write_mask: cover property (do_wr && awa_q == OFF_IMASK);
  c_isr_tx_read: cover property (isr_rd && src == SRC_TXR);
  c_timeout: cover property (tout_exp ##1 to_f_q);
  c_flow_evt: cover property ($rose(fl_f_q));
endmodule // uicf_ctrl

// ===== testbench/uicf_host_model.sv
`timescale 1ns/1ps
module uicf_host_model (
  input wire logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Released payloads are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h000000, d};
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // uicf_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import uicf_pkg::*;
  localparam int P_CHAR = 0, P_XOFF = 1, P_XON = 2, P_LCR = 3;
  localparam int P_MCR = 4, P_RHR = 5, P_TICK = 6, P_THW = 7;
  logic clk, rst_n, rhr_full, thr_empty, cts_in, irq_pending, fifo_en;
  logic auto_cts_en;
  logic dma_mode, rx_fifo_reset, tx_fifo_reset;
  logic rx_dma_request_pin_n, tx_dma_request_pin_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, line_err, modem_delta, char_bits;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] pl;
  uicf_lvl_t rx_level, tx_level;
  int failures, samples_checked, n_rxr, n_txr;

  uicf_host_model hm (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  uicf_ctrl dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_level,
    .tx_level, .rhr_full, .thr_empty, .tx_empty(1'b0), .line_err,
    .modem_delta, .cts_in, .rts_out(1'b0), .char_rx(pl[0]),
    .xoff_rx(pl[1]), .xon_rx(pl[2]), .special_rx(1'b0),
    .line_condition_read(pl[3]), .modem_condition_read(pl[4]),
    .receive_holding_read(pl[5]), .transmit_holding_write(pl[7]),
    .bit_tick(pl[6]), .char_bits, .fifo_en, .rx_fifo_reset,
    .tx_fifo_reset, .dma_mode, .auto_cts_en, .auto_rts_en(),
    .rs485_en(), .irq_pending, .rx_dma_request_pin_n,
    .tx_dma_request_pin_n);

  always @(posedge clk) begin
    if (rx_fifo_reset === 1'b1) n_rxr++;
    if (tx_fifo_reset === 1'b1) n_txr++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    hm.wr(a, d, r);
    chk(32'(r), 32'(AXI_OKAY));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    hm.rd(a, d, r);
    chk(d, {24'h000000, e});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pl <= 8'(1 << i);
    @(posedge clk);
    pl <= 8'h00;
  endtask
  function automatic logic [7:0] trig_a(input logic [1:0] s);
    case (s)
      2'h0: return 8'h01;
      2'h1: return 8'h04;
      2'h2: return 8'h08;
      default: return 8'h0e;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    logic [7:0] r, lvl;
    logic [1:0] s, rsp;
    logic [31:0] d;
    rst_n = 1'b0;
    pl = 8'h00;
    rx_level = 8'h00;
    tx_level = 8'h00;
    rhr_full = 1'b0;
    thr_empty = 1'b1;
    cts_in = 1'b0;
    line_err = 4'h0;
    modem_delta = 4'h0;
    char_bits = 4'h8;
    void'($urandom(97242));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk({30'h0, rx_dma_request_pin_n, tx_dma_request_pin_n}, 32'h3);
    rchk(OFF_ISRC, 8'h01);
    rchk(OFF_IMASK, 8'h00);
    // Gate closed, upper mask bits must not take
    w(OFF_IMASK, 8'hff);
    rchk(OFF_IMASK, 8'h0f);
    rhr_full <= 1'b1;
    modem_delta <= 4'h4;
    @(posedge clk);
    modem_delta <= 4'h0;
    line_err <= 4'h2;
    pulse(P_CHAR);
    line_err <= 4'h0;
    repeat (3) @(posedge clk);
    chk(32'(irq_pending), 32'h1);
    rchk(OFF_ISRC, 8'h06);
    pulse(P_LCR);
    rchk(OFF_ISRC, 8'h04);
    rhr_full <= 1'b0;
    rchk(OFF_ISRC, 8'h02);
    rchk(OFF_ISRC, 8'h00);
    pulse(P_MCR);
    rchk(OFF_ISRC, 8'h01);
    chk(32'(irq_pending), 32'h0);
    w(OFF_IMASK, 8'h00);
    w(OFF_EFR, 8'h90);
    chk(32'(auto_cts_en), 32'h1);
    w(OFF_IMASK, 8'ha0);
    pulse(P_XOFF);
    repeat (3) @(posedge clk);
    chk(32'(irq_pending), 32'h1);
    pulse(P_XON);
    repeat (3) @(posedge clk);
    chk(32'(irq_pending), 32'h0);
    cts_in <= 1'b1;
    rchk(OFF_ISRC, 8'h20);
    pulse(P_MCR);
    rchk(OFF_ISRC, 8'h01);
    // Bit 1 kept clear: an enable with an empty holding reg interrupts
    for (int i = 0; i < 6; i++) begin
      r = 8'($urandom) & 8'hfd;
      w(OFF_IMASK, r);
      rchk(OFF_IMASK, r);
    end
    w(OFF_EFR, 8'h00);
    w(OFF_IMASK, 8'h00);
    rchk(OFF_IMASK, {r[7:4], 4'h0});
    w(OFF_FSET, 8'h06);
    chk(32'(fifo_en), 32'h0);
    chk(n_rxr + n_txr, 0);
    w(OFF_FSET, 8'h07);
    repeat (2) @(posedge clk);
    chk(n_rxr, 1);
    chk(n_txr, 1);
    w(OFF_FSET, 8'h09);
    chk(32'(dma_mode), 32'h1);
    // Pins are registered one edge behind the mode bit
    @(posedge clk);
    chk({30'h0, rx_dma_request_pin_n, tx_dma_request_pin_n}, 32'h2);
    rchk(OFF_FSET, 8'h00);
    rchk(OFF_ISRC, 8'hc1);
    w(OFF_IMASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      s = (i < 2) ? 2'h3 : 2'($urandom);
      lvl = (i < 2) ? 8'(13 + i) : 8'($urandom % 20);
      rx_level <= lvl;
      w(OFF_FSET, {s, 6'h01});
      rchk(OFF_ISRC, (lvl >= trig_a(s)) ? 8'hc4 : 8'hc1);
    end
    w(OFF_FSET, 8'h01);
    rx_level <= 8'h01;
    rchk(OFF_ISRC, 8'hc4);
    repeat (43) pulse(P_TICK);
    rchk(OFF_ISRC, 8'hc4);
    pulse(P_TICK);
    rchk(OFF_ISRC, 8'hcc);
    pulse(P_RHR);
    rchk(OFF_ISRC, 8'hc4);
    rx_level <= 8'h00;
    // Enabling with an empty transmit FIFO interrupts at once
    w(OFF_IMASK, 8'h02);
    rchk(OFF_ISRC, 8'hc2);
    rchk(OFF_ISRC, 8'hc1);
    w(OFF_TTAB, 8'h30);
    w(OFF_TRG, 8'h05);
    rchk(OFF_TRG, 8'h05);
    w(OFF_TTAB, 8'hb0);
    w(OFF_TRG, 8'h04);
    rchk(OFF_TRG, 8'h04);
    // Reload above the trigger, then fall below it
    tx_level <= 8'h06;
    @(posedge clk);
    tx_level <= 8'h03;
    repeat (3) @(posedge clk);
    chk(32'(irq_pending), 32'h1);
    pulse(P_THW);
    rchk(OFF_ISRC, 8'hc1);
    // Empty after an overfilled reload stays quiet
    tx_level <= 8'h00;
    rchk(OFF_ISRC, 8'hc1);
    tx_level <= 8'h02;
    @(posedge clk);
    tx_level <= 8'h00;
    rchk(OFF_ISRC, 8'hc2);
    hm.rd(8'h18, d, rsp);
    chk(32'(rsp), 32'(AXI_SLVERR));
    hm.wr(OFF_ISRC, 8'h00, rsp);
    chk(32'(rsp), 32'(AXI_SLVERR));
    test_done();
  end
endmodule // tb
